// [rtl/lhs_pkg.sv]
package lhs_pkg;
	// timing figures and the cycle counts they give at mclk
	localparam int MCLK_HZ              = 10000000;
	localparam int CHOPPER_FREQUENCY_HZ = 115000;
	localparam int ENABLE_DELAY_US      = 70;
	// one chopper period, rounded down so updates never come late
	localparam int CHOP_CYCLES          = MCLK_HZ / CHOPPER_FREQUENCY_HZ;
	localparam int HALF_CYCLES          = CHOP_CYCLES / 2;
	// longest enable time: round down
	localparam int ENABLE_CYCLES        = (ENABLE_DELAY_US * (MCLK_HZ / 1000000));
	localparam int FIELD_W              = 12;
	// thresholds in signed field units, south positive
	localparam int ON_THRESHOLD         = 80;
	localparam int OFF_THRESHOLD        = -80;
	localparam int ALT_FIELD_MAX_HZ     = 10000;

	typedef enum logic [1:0]
	{
		LHS_PHASE_START  = 2'b00,
		LHS_PHASE_FIRST  = 2'b01,
		LHS_PHASE_SECOND = 2'b10
	} lhs_phase_t;
endpackage

// [rtl/lhs_chopper_clock.sv]
`timescale 1ns/100ps
// two-phase chopper clock from the internal oscillator
module lhs_chopper_clock
	import lhs_pkg::*;
#(
	parameter int HALF = HALF_CYCLES
)
(
	input  wire logic mclk,
	input  wire logic rst_n,
	output logic      first_end,
	output logic      second_end
);
	initial
	begin
		if (HALF < 2)
			$error("half period too short");
	end

	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic        phase_reg;
	logic        phase_next;
	logic        first_end_reg;
	logic        first_end_next;
	logic        second_end_reg;
	logic        second_end_next;

	always_comb
	begin
		count_next      = count_reg + 16'h0001;
		phase_next      = phase_reg;
		first_end_next  = 1'b0;
		second_end_next = 1'b0;
		if (count_reg == 16'(HALF - 1))
		begin
			count_next      = 16'h0000;
			phase_next      = ~phase_reg;
			first_end_next  = ~phase_reg;
			second_end_next = phase_reg;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			count_reg      <= 16'h0000;
			phase_reg      <= 1'b0;
			first_end_reg  <= 1'b0;
			second_end_reg <= 1'b0;
		end
		else
		begin
			count_reg      <= count_next;
			phase_reg      <= phase_next;
			first_end_reg  <= first_end_next;
			second_end_reg <= second_end_next;
		end
	end

	assign first_end  = first_end_reg;
	assign second_end = second_end_reg;
endmodule

// [rtl/lhs_latching_hall_switch_sampler.sv]
`timescale 1ns/100ps
// What this block does
// - output pulled low once a south field above the on threshold is seen.
// - output released high once a north field beyond the off threshold is seen.
// - output holds between thresholds or with no field; only the opposite pole flips it.
// - on and off thresholds differ, so a hovering field cannot make it chatter.
// - the compensation cycle runs at the chopper frequency, 115 kHz typical.
// - each cycle is one first phase followed by one second phase.
// - the field is captured at the end of the first phase and held through the second.
// - at the end of the second phase sample and present field are averaged and compared.
// - the output follows a crossing within zero to one and a half chopper periods.
// - static fields and alternating fields up to 10 kHz are tracked.
// - the output transistor is off while overtemperature persists.
// - after power-up a valid output appears within the 70 us enable time.
module lhs_latching_hall_switch_sampler
	import lhs_pkg::*;
#(
	parameter int W       = FIELD_W,
	parameter int ON_TH   = ON_THRESHOLD,
	parameter int OFF_TH  = OFF_THRESHOLD,
	parameter int HALF    = HALF_CYCLES,
	parameter int EN_CYC  = ENABLE_CYCLES
)
(
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic signed [W-1:0] field,
	input  wire logic                over_temp,
	output logic                     out_o,
	output logic                     out_oe,
	output logic                     out_valid
);
	// counters share one width; parameters beyond it are refused below
	localparam int CNT_W     = 16;
	localparam int CNT_MAX   = (1 << CNT_W) - 1;
	localparam int FIELD_MAX = (1 << (W - 1)) - 1;
	localparam int FIELD_MIN = -(1 << (W - 1));
	// comparator slots, one per threshold
	localparam int CMP_ON    = 0;
	localparam int CMP_OFF   = 1;
	localparam int CMP_N     = 2;

	initial
	begin
		if (W < 4)
		begin
			$error("field width too small");
		end
		if (OFF_TH >= ON_TH)
		begin
			$error("off threshold must lie below on threshold");
		end
		if (ON_TH > FIELD_MAX || OFF_TH < FIELD_MIN)
		begin
			$error("thresholds outside the field range");
		end
		if (HALF < 2 || HALF > CNT_MAX)
		begin
			$error("half period outside the counter range");
		end
		if (2 * HALF * ALT_FIELD_MAX_HZ > MCLK_HZ / 2)
		begin
			$error("chopper too slow for alternating fields");
		end
		if (EN_CYC < 2 * HALF)
		begin
			$error("enable time shorter than one cycle");
		end
		if (EN_CYC > CNT_MAX)
		begin
			$error("enable time beyond the counter range");
		end
	end

	// chopper phase strobes, one mclk wide each
	logic first_end;
	logic second_end;

	lhs_chopper_clock #(
		.HALF (HALF)
	) lhs_chopper_clock_inst (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.first_end  (first_end),
		.second_end (second_end)
	);

	// strictly past a threshold in the given direction; equal never counts
	function automatic logic beyond(
		input logic signed [W:0] level,
		input int                th,
		input logic              upward
	);
		logic result;
		result = 1'b0;
		if (upward)
		begin
			result = (level > (W+1)'(th));
		end
		else
		begin
			result = (level < (W+1)'(th));
		end
		return result;
	endfunction

	// threshold opposite to the latched state, so a hovering field cannot chatter
	function automatic logic decide(
		input logic             latched,
		input logic [CMP_N-1:0] past
	);
		logic result;
		result = latched;
		if (!latched)
		begin
			result = past[CMP_ON];
		end
		else
		begin
			result = !past[CMP_OFF];
		end
		return result;
	endfunction

	lhs_phase_t             phase_reg;
	lhs_phase_t             phase_next;
	logic signed [W-1:0]    sample_reg;
	logic signed [W-1:0]    sample_next;
	logic signed [W:0]      sum;
	logic signed [W:0]      avg;
	logic [CMP_N-1:0]       crossed;
	logic                   decide_now;
	logic                   on_reg;
	logic                   on_next;
	logic [CNT_W-1:0]       en_cnt_reg;
	logic [CNT_W-1:0]       en_cnt_next;
	logic                   valid_reg;
	logic                   valid_next;
	logic                   oe_reg;
	logic                   oe_next;

	// phase tracker: start leaves at once, then first and second alternate
	always_comb
	begin
		phase_next = phase_reg;
		case (phase_reg)
			LHS_PHASE_START:
			begin
				phase_next = LHS_PHASE_FIRST;
			end
			LHS_PHASE_FIRST:
			begin
				if (first_end)
				begin
					phase_next = LHS_PHASE_SECOND;
				end
			end
			LHS_PHASE_SECOND:
			begin
				if (second_end)
				begin
					phase_next = LHS_PHASE_FIRST;
				end
			end
			default:
			begin
				phase_next = LHS_PHASE_START;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			phase_reg <= LHS_PHASE_START;
		end
		else
		begin
			phase_reg <= phase_next;
		end
	end

	// held sample: taken as the first phase closes, kept through the second
	always_comb
	begin
		sample_next = sample_reg;
		if (phase_reg == LHS_PHASE_FIRST && first_end)
		begin
			sample_next = field;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			sample_reg <= '0;
		end
		else
		begin
			sample_reg <= sample_next;
		end
	end

	// one spare bit holds the sum, so the arithmetic halving cannot overflow
	assign sum = (W+1)'(sample_reg) + (W+1)'(field);
	assign avg = sum >>> 1;

	// one comparator per threshold, both always running
	generate
		for (genvar k = 0; k < CMP_N; k++)
		begin : g_compare
			assign crossed[k] = beyond(avg, (k == CMP_ON) ? ON_TH : OFF_TH, k == CMP_ON);
		end
	endgenerate

	// a step just after a first-phase close meets the old sample in the average,
	// so the switch can slip a cycle; that is the price of cancelling offset
	assign decide_now = (phase_reg == LHS_PHASE_SECOND) && second_end;

	// latched pole: only a decision strobe may flip it
	always_comb
	begin
		on_next = on_reg;
		if (decide_now)
		begin
			on_next = decide(on_reg, crossed);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			on_reg <= 1'b0;
		end
		else
		begin
			on_reg <= on_next;
		end
	end

	// valid after the first decision, or at the latest once the enable time runs out
	always_comb
	begin
		en_cnt_next = en_cnt_reg;
		valid_next  = valid_reg;
		if (!valid_reg)
		begin
			if (decide_now)
			begin
				valid_next = 1'b1;
			end
			else if (en_cnt_reg == CNT_W'(EN_CYC - 1))
			begin
				valid_next = 1'b1;
			end
			else
			begin
				en_cnt_next = en_cnt_reg + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			en_cnt_reg <= '0;
			valid_reg  <= 1'b0;
		end
		else
		begin
			en_cnt_reg <= en_cnt_next;
			valid_reg  <= valid_next;
		end
	end

	// overtemperature forces the transistor off but keeps the latch,
	// so the output returns as soon as the die cools
	always_comb
	begin
		oe_next = on_next;
		if (over_temp)
		begin
			oe_next = 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			oe_reg <= 1'b0;
		end
		else
		begin
			oe_reg <= oe_next;
		end
	end

	// open drain: the pin is only ever pulled low, the load gives the high level
	assign out_o     = 1'b0;
	assign out_oe    = oe_reg;
	assign out_valid = valid_reg;
endmodule

// [sim/lhs_sva.sv]
`timescale 1ns/100ps
module lhs_sva
	import lhs_pkg::*;
#(
	parameter int W      = FIELD_W,
	parameter int ON_TH  = ON_THRESHOLD,
	parameter int OFF_TH = OFF_THRESHOLD,
	parameter int EN_CYC = ENABLE_CYCLES
)
(
	input wire logic                mclk,
	input wire logic                rst_n,
	input wire logic signed [W-1:0] field,
	input wire logic                over_temp,
	input wire logic                out_o,
	input wire logic                out_oe,
	input wire logic                out_valid
);
	logic [9:0] t_reg;
	logic [9:0] s_reg;
	logic [9:0] n_reg;
	logic [9:0] q_reg;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// run lengths saturate; 140 covers a held sample plus a full decision
	always_ff @(posedge mclk)
	begin
		t_reg <= !rst_n ? '0 : t_reg + 10'(t_reg < 10'h3ff);
		s_reg <= (rst_n && field > ON_TH && !over_temp) ? s_reg + 10'(s_reg < 10'h3ff) : '0;
		n_reg <= (rst_n && field < OFF_TH && !over_temp) ? n_reg + 10'(n_reg < 10'h3ff) : '0;
		q_reg <= (rst_n && field >= OFF_TH && field <= ON_TH && !over_temp) ?
			q_reg + 10'(q_reg < 10'h3ff) : '0;
	end
	ot_off_a: assert property (over_temp |=> !out_oe) else $error("on in overtemp");
	drain_only_a: assert property (out_o == 1'b0) else $error("drain high");
	south_on_a: assert property (s_reg == 140 |-> out_oe) else $error("south missed");
	north_off_a: assert property (n_reg == 140 |-> !out_oe) else $error("north missed");
	quiet_hold_a: assert property (q_reg > 140 |-> $stable(out_oe)) else $error("drift");
	valid_by_a: assert property (t_reg == EN_CYC + 2 |-> out_valid) else $error("late");
	valid_keep_a: assert property (out_valid |=> out_valid) else $error("valid lost");
	rise_valid_a: assert property ($rose(out_oe) |-> ##[0:1] out_valid) else $error("early");
endmodule
bind lhs_latching_hall_switch_sampler lhs_sva #(.W(W), .ON_TH(ON_TH), .OFF_TH(OFF_TH),
	.EN_CYC(EN_CYC)) lhs_sva_inst (.mclk, .rst_n, .field, .over_temp, .out_o, .out_oe, .out_valid);

// [sim/lhs_magnet.sv]
`timescale 1ns/100ps
module lhs_magnet
	import lhs_pkg::*;
(
	input  wire logic signed [FIELD_W-1:0] level,
	input  wire logic                      out_o,
	input  wire logic                      out_oe,
	output logic signed [FIELD_W-1:0]      field,
	output logic                           pin
);
	// pull-up load: line high unless the switch sinks it
	assign pin = out_oe ? out_o : 1'b1;
	assign field = level;
endmodule

// [sim/lhs_latching_hall_switch_sampler_bench.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module lhs_latching_hall_switch_sampler_bench;
	import lhs_pkg::*;
	logic                      mclk;
	logic                      rst_n;
	logic                      over_temp;
	logic                      out_o;
	logic                      out_oe;
	logic                      out_valid;
	logic                      pin;
	logic signed [FIELD_W-1:0] level;
	logic signed [FIELD_W-1:0] field;
	int                        n_errors;
	int                        checks;
	lhs_latching_hall_switch_sampler lhs_latching_hall_switch_sampler_inst (.mclk, .rst_n,
		.field, .over_temp, .out_o, .out_oe, .out_valid);
	lhs_magnet lhs_magnet_inst (.level, .out_o, .out_oe, .field, .pin);
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic run(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic complete_run;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// 500 cycles is half of a 10 kHz field period
	task automatic alt_poles;
		for (int i = 0; i < 4; i++)
		begin
			level = i[0] ? -12'sd100 : 12'sd100;
			run(500);
			`CHK(pin, i[0])
		end
	endtask
	task automatic hold_band;
		level = 12'sd100;
		run(200);
		level = 12'sd80;
		run(300);
		`CHK(pin, 1'b0)
		level = -12'sd80;
		run(300);
		`CHK(pin, 1'b0)
		level = -12'sd81;
		run(200);
		`CHK(pin, 1'b1)
		level = 12'sd80;
		run(300);
		`CHK(pin, 1'b1)
	endtask
	task automatic hot_output;
		level = 12'sd100;
		run(200);
		over_temp = 1'b1;
		run(2);
		`CHK(pin, 1'b1)
		over_temp = 1'b0;
		run(2);
		`CHK(pin, 1'b0)
	endtask
	// second power-up with a south field already present
	task automatic restart_south;
		level = 12'sd100;
		rst_n = 1'b0;
		run(4);
		rst_n = 1'b1;
		`CHK(pin, 1'b1)
		`CHK(out_valid, 1'b0)
		run(ENABLE_CYCLES);
		`CHK(out_valid, 1'b1)
		`CHK(pin, 1'b0)
	endtask
	initial
	begin
		rst_n = 1'b0;
		over_temp = 1'b0;
		level = '0;
		run(4);
		rst_n = 1'b1;
		`CHK(pin, 1'b1)
		`CHK(out_valid, 1'b0)
		alt_poles();
		`CHK(out_valid, 1'b1)
		hold_band();
		hot_output();
		restart_south();
		complete_run();
	end
	initial
	begin
		#1000000;
		n_errors++;
		complete_run();
	end
endmodule
